// ==== src/adc_wrap_and_trigger_select.sv ====
/*
 * Wrap-around channel counter, external trigger source select, digital
 * input enables, pin level readback and result register byte layout.
 * Assumes analog pins and trigger inputs are asynchronous, results arrive
 * from the conversion core on mclk, and the register master never waits.
 */
module adc_wrap_and_trigger_select #(
    parameter int N_CH      = 16,
    parameter int RES_W     = 10,
    parameter bit HAS_DEDTR = 1'b1
) (
    input  wire logic                   mclk,
    input  wire logic                   reset_n,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    input  wire logic [5:0]             reg_addr,
    input  wire logic [7:0]             reg_wdata,
    output logic      [7:0]             reg_rdata,
    input  wire logic [N_CH-1:0]        analog_pin_level,
    input  wire logic [3:0]             dedicated_trigger_inputs,
    input  wire logic                   multi_channel_mode,
    input  wire logic                   seq_start,
    input  wire logic                   conv_done,
    input  wire logic                   eight_bit_mode,
    input  wire logic [RES_W-1:0]       conv_result,
    output logic                        seq_active,
    output logic                        seq_abort,
    output logic      [3:0]             conv_channel,
    output logic                        ext_trigger
);

    // ****************************************************************
    // Request bundle and decode
    // ****************************************************************
    wrap_trig_pkg::reg_req_t req;
    assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};


    // ****************************************************************
    // Write decode
    // ****************************************************************
    logic       wr_wrap;
    logic       wr_trig;
    logic       wr_den_h;
    logic       wr_den_l;

    always_comb begin
        wr_wrap  = 1'b0;
        wr_trig  = 1'b0;
        wr_den_h = 1'b0;
        wr_den_l = 1'b0;
        if (req.wr) begin
            if (req.addr == wrap_trig_pkg::WRAP_CTRL_OFS) begin
                wr_wrap = 1'b1;
            end else if (req.addr == wrap_trig_pkg::TRIG_CTRL_OFS) begin
                wr_trig = 1'b1;
            end else if (req.addr == wrap_trig_pkg::DIG_EN_HIGH_OFS) begin
                wr_den_h = 1'b1;
            end else if (req.addr == wrap_trig_pkg::DIG_EN_LOW_OFS) begin
                wr_den_l = 1'b1;
            end
        end
    end

    // ****************************************************************
    // Control registers
    // ****************************************************************
    logic [3:0]  wrap_sel_reg;
    wrap_trig_pkg::trig_cfg_t trig_cfg_reg;
    logic [15:0] dig_en_reg;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wrap_sel_reg <= wrap_trig_pkg::WRAP_CTRL_RST[3:0];
        end else if (wr_wrap) begin
            wrap_sel_reg <= req.wdata[3:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            trig_cfg_reg <= '{trig_source_kind:
                                  wrap_trig_pkg::TRIG_CTRL_RST[wrap_trig_pkg::TRIG_KIND_BIT],
                              trig_channel_field: wrap_trig_pkg::TRIG_CTRL_RST[3:0]};
        end else if (wr_trig) begin
            // Bit is always stored, even without dedicated inputs
            trig_cfg_reg <= '{trig_source_kind: req.wdata[wrap_trig_pkg::TRIG_KIND_BIT],
                              trig_channel_field: req.wdata[3:0]};
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            dig_en_reg <= {wrap_trig_pkg::DIG_EN_RST, wrap_trig_pkg::DIG_EN_RST};
        end else begin
            if (wr_den_h) begin
                dig_en_reg[15:8] <= req.wdata;
            end
            if (wr_den_l) begin
                dig_en_reg[7:0] <= req.wdata;
            end
        end
    end

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [N_CH-1:0] pin_s1_reg;
    logic [N_CH-1:0] pin_s2_reg;
    logic [3:0]      ded_s1_reg;
    logic [3:0]      ded_s2_reg;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= analog_pin_level;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // Kept apart so the trigger inputs can be left out on their own
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ded_s1_reg <= '0;
            ded_s2_reg <= '0;
        end else begin
            ded_s1_reg <= dedicated_trigger_inputs;
            ded_s2_reg <= ded_s1_reg;
        end
    end

    // ****************************************************************
    // Pin level readback
    // ****************************************************************
    logic [15:0] pin_view;
    genvar g;
    generate
        for (g = 0; g < 16; g++) begin : g_pin
            if (g < N_CH) begin : g_live
                assign pin_view[g] = dig_en_reg[g] ? pin_s2_reg[g]
                                   : wrap_trig_pkg::PIN_DISABLED_VAL[g % 8];
            end else begin : g_none
                assign pin_view[g] = wrap_trig_pkg::PIN_DISABLED_VAL[g % 8];
            end
        end
    endgenerate

    // ****************************************************************
    // Trigger source select
    // ****************************************************************
    logic use_dedicated;
    logic ext_trigger_next;
    assign use_dedicated = HAS_DEDTR && trig_cfg_reg.trig_source_kind;

    always_comb begin
        ext_trigger_next = 1'b0;
        if (!use_dedicated) begin
            ext_trigger_next = pin_s2_reg[trig_cfg_reg.trig_channel_field];
        end else if (trig_cfg_reg.trig_channel_field <= wrap_trig_pkg::DED_TRIG_LAST) begin
            ext_trigger_next = ded_s2_reg[trig_cfg_reg.trig_channel_field[1:0]];
        end
        // Reserved codes give a trigger that never fires
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ext_trigger <= 1'b0;
        end else begin
            ext_trigger <= ext_trigger_next;
        end
    end

    // ****************************************************************
    // Sequence control and channel counter
    // ****************************************************************
    typedef enum logic [1:0] {
        SEQ_IDLE = 2'b01,
        SEQ_RUN  = 2'b10
    } seq_state_t;

    seq_state_t seq_reg;
    logic       abort_now;
    logic [3:0] last_ch;
    assign abort_now = wr_wrap || wr_trig;
    // Zero is reserved; treated as wrap after channel 0 to avoid a stuck counter
    assign last_ch   = wrap_sel_reg;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            seq_reg <= SEQ_IDLE;
        end else begin
            case (seq_reg)
                SEQ_IDLE: begin
                    // Abort beats a start in the same cycle
                    if (seq_start && !abort_now) begin
                        seq_reg <= SEQ_RUN;
                    end
                end
                SEQ_RUN: begin
                    if (abort_now) begin
                        seq_reg <= SEQ_IDLE;
                    end
                end
                default: begin
                    seq_reg <= SEQ_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Abort pulse
    // ****************************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            seq_abort <= 1'b0;
        end else begin
            seq_abort <= abort_now && (seq_reg == SEQ_RUN);
        end
    end

    assign seq_active = (seq_reg == SEQ_RUN);

    // ****************************************************************
    // Channel counter
    // ****************************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            conv_channel <= 4'h0;
        end else if (seq_reg == SEQ_IDLE || abort_now) begin
            conv_channel <= 4'h0;
        end else if (conv_done && multi_channel_mode) begin
            if (conv_channel >= last_ch) begin
                conv_channel <= 4'h0;
            end else begin
                conv_channel <= conv_channel + 4'h1;
            end
        end
    end

    // ****************************************************************
    // Result layout
    // ****************************************************************
    logic [15:0] result_fmt;
    assign result_fmt = eight_bit_mode ? {conv_result[7:0], 8'h00}
                                       : {conv_result[9:0], 6'h00};

    // ****************************************************************
    // Result storage
    // ****************************************************************
    logic [15:0] result_mem [0:15];
    logic        store_en;
    // A control write drops the result that lands in the same cycle
    assign store_en = conv_done && (seq_reg == SEQ_RUN) && !abort_now;

    genvar r;
    generate
        for (r = 0; r < 16; r++) begin : g_res
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    result_mem[r] <= 16'h0000;
                end else if (store_en && (conv_channel == 4'(r))) begin
                    result_mem[r] <= result_fmt;
                end
            end
        end
    endgenerate

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [7:0]  ctrl_rdata;
    logic [7:0]  res_rdata;
    logic [7:0]  rdata_next;
    logic        res_hit;
    logic [4:0]  res_idx;
    logic [15:0] res_word;
    assign res_idx  = 5'(req.addr - wrap_trig_pkg::RESULT_BASE_OFS);
    assign res_hit  = (req.addr >= wrap_trig_pkg::RESULT_BASE_OFS)
                      && (req.addr <= wrap_trig_pkg::RESULT_LAST_OFS);
    assign res_word = result_mem[res_idx[4:1]];

    // Control, enable and pin registers
    always_comb begin
        ctrl_rdata = 8'h00;
        if (req.addr == wrap_trig_pkg::WRAP_CTRL_OFS) begin
            ctrl_rdata = {4'h0, wrap_sel_reg};
        end else if (req.addr == wrap_trig_pkg::TRIG_CTRL_OFS) begin
            ctrl_rdata = {trig_cfg_reg.trig_source_kind, 3'b000,
                          trig_cfg_reg.trig_channel_field};
        end else if (req.addr == wrap_trig_pkg::DIG_EN_HIGH_OFS) begin
            ctrl_rdata = dig_en_reg[15:8];
        end else if (req.addr == wrap_trig_pkg::DIG_EN_LOW_OFS) begin
            ctrl_rdata = dig_en_reg[7:0];
        end else if (req.addr == wrap_trig_pkg::PIN_HIGH_OFS) begin
            ctrl_rdata = pin_view[15:8];
        end else if (req.addr == wrap_trig_pkg::PIN_LOW_OFS) begin
            ctrl_rdata = pin_view[7:0];
        end
    end

    // Even offset high byte, odd offset low byte
    always_comb begin
        res_rdata = 8'h00;
        if (res_hit) begin
            if (res_idx[0]) begin
                res_rdata = res_word[7:0];
            end else begin
                res_rdata = res_word[15:8];
            end
        end
    end

    // Unmapped offsets fall through to zero
    assign rdata_next = res_hit ? res_rdata : ctrl_rdata;

    // ****************************************************************
    // Read data register
    // ****************************************************************

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (req.rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule : adc_wrap_and_trigger_select

// ==== src/wrap_trig_pkg.sv ====
/*
 * Shared constants and types for the converter wrap and trigger select block.
 * Assumes a single clock domain and a plain register port with byte data.
 */
package wrap_trig_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [5:0] WRAP_CTRL_OFS    = 6'h00;
    localparam logic [5:0] TRIG_CTRL_OFS    = 6'h01;
    localparam logic [5:0] DIG_EN_HIGH_OFS  = 6'h0c;
    localparam logic [5:0] DIG_EN_LOW_OFS   = 6'h0d;
    localparam logic [5:0] PIN_HIGH_OFS     = 6'h0e;
    localparam logic [5:0] PIN_LOW_OFS      = 6'h0f;
    localparam logic [5:0] RESULT_BASE_OFS  = 6'h10;
    localparam logic [5:0] RESULT_LAST_OFS  = 6'h2f;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int         TRIG_KIND_BIT    = 7;
    localparam logic [7:0] WRAP_CTRL_RST    = 8'h0f;
    localparam logic [7:0] TRIG_CTRL_RST    = 8'h00;
    localparam logic [7:0] DIG_EN_RST       = 8'h00;
    localparam logic [7:0] PIN_DISABLED_VAL = 8'h00;
    localparam logic [3:0] DED_TRIG_LAST    = 4'h3;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic       trig_source_kind;
        logic [3:0] trig_channel_field;
    } trig_cfg_t;

endpackage : wrap_trig_pkg

// ==== test/wrap_trig_monitor.sv ====
/* Checker for the converter wrap and trigger select block.
   Assumes it is bound to the top module and sees only its ports. */
module wrap_trig_monitor (
    input wire logic       mclk,
    input wire logic       reset_n,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       multi_channel_mode,
    input wire logic       conv_done,
    input wire logic       seq_active,
    input wire logic       seq_abort,
    input wire logic [3:0] conv_channel,
    input wire logic       ext_trigger
);
    // ****
    // Shadow of the control registers
    // ****
    logic [3:0] wrap_q;
    logic [7:0] trig_q;
    logic       ctrl_wr;
    assign ctrl_wr = reg_wr && reg_addr[5:1] == 5'h00;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wrap_q <= 4'hf;
            trig_q <= 8'h00;
        end else if (reg_wr && reg_addr == 6'h00) begin
            wrap_q <= reg_wdata[3:0];
        end else if (reg_wr && reg_addr == 6'h01) begin
            trig_q <= reg_wdata & 8'h8f;
        end
    end
    default clocking dc @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ****
    // Properties
    // ****
    property p_abort;
        ctrl_wr && seq_active |=> seq_abort && !seq_active && conv_channel == 4'h0;
    endproperty
    a_abort: assert property (p_abort) else $error("run not aborted");
    property p_no_start;
        ctrl_wr && !seq_active |=> !seq_active;
    endproperty
    a_no_start: assert property (p_no_start) else $error("write started a run");
    property p_wrap;
        seq_active && conv_done && multi_channel_mode && !ctrl_wr && conv_channel == wrap_q
            |=> conv_channel == 4'h0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap to channel 0");
    property p_advance;
        seq_active && conv_done && multi_channel_mode && !ctrl_wr && conv_channel != wrap_q
            |=> conv_channel == $past(conv_channel) + 4'h1;
    endproperty
    a_advance: assert property (p_advance) else $error("channel not advanced");
    // Data stands only in the cycle after the strobe
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_rd_wrap;
        reg_rd && reg_addr == 6'h00 |=> reg_rdata == {4'h0, wrap_q};
    endproperty
    a_rd_wrap: assert property (p_rd_wrap) else $error("wrap readback");
    property p_rd_trig;
        reg_rd && reg_addr == 6'h01 |=> reg_rdata == trig_q;
    endproperty
    a_rd_trig: assert property (p_rd_trig) else $error("trigger readback");
    property p_reserved;
        (trig_q[7] && trig_q[3:2] != 2'b00) [*3] |-> !ext_trigger;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved code fired");
    c_abort: cover property (seq_abort);
    c_wrap: cover property (conv_done && conv_channel == 4'hf);
    c_rd: cover property (reg_rd && reg_addr == 6'h01);
endmodule : wrap_trig_monitor

bind adc_wrap_and_trigger_select wrap_trig_monitor i_wrap_trig_monitor (.mclk, .reset_n,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .multi_channel_mode, .conv_done,
    .seq_active, .seq_abort, .conv_channel, .ext_trigger);

// ==== test/tb_top.sv ====
/* Self-checking bench for the converter wrap and trigger select block.
   Assumes the default parameters, dedicated trigger inputs present. */
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin n_errors++; $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk = 1'b0;
    logic        reset_n, reg_wr, reg_rd, seq_start, conv_done, multi_channel_mode;
    logic        eight_bit_mode, seq_active, seq_abort, ext_trigger;
    logic [5:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, got;
    logic [15:0] analog_pin_level;
    logic [3:0]  dedicated_trigger_inputs, conv_channel;
    logic [9:0]  conv_result;
    int          n_errors = 0, n_checks = 0, cyc = 0;
    logic [21:0] rows [8] = '{{6'h00, 8'hff, 8'h0f}, {6'h00, 8'h01, 8'h01},
        {6'h01, 8'hff, 8'h8f}, {6'h01, 8'h83, 8'h83}, {6'h0c, 8'ha5, 8'ha5},
        {6'h0d, 8'h5a, 8'h5a}, {6'h07, 8'hff, 8'h00}, {6'h0f, 8'hff, 8'h00}};
    logic [7:0]  res_exp [4] = '{8'hc8, 8'h00, 8'hb2, 8'h40};
    adc_wrap_and_trigger_select i_adc_wrap_and_trigger_select (.mclk, .reset_n, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .analog_pin_level,
        .dedicated_trigger_inputs, .multi_channel_mode, .seq_start, .conv_done,
        .eight_bit_mode, .conv_result, .seq_active, .seq_abort, .conv_channel, .ext_trigger);
    always #4 mclk = ~mclk;
    // ****
    // Bus and stimulus tasks
    // ****
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [5:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 got = reg_rdata;
    endtask : rd
    // Inputs pass a two-stage sync, so settle before looking
    task automatic trig(input logic [7:0] c, input logic [15:0] p, input logic [3:0] d,
                        input logic e);
        wr(6'h01, c);
        @(posedge mclk);
        analog_pin_level <= p;
        dedicated_trigger_inputs <= d;
        repeat (5) @(posedge mclk);
        #1 `CHK("trigger", e, ext_trigger)
    endtask : trig
    task automatic run_wrap(input int w);
        wr(6'h00, 8'(w));
        @(posedge mclk);
        seq_start <= 1'b1;
        @(posedge mclk);
        seq_start <= 1'b0;
        #1 `CHK("start", 5'h10, {seq_active, conv_channel})
        for (int i = 1; i <= w + 1; i++) begin
            @(posedge mclk);
            conv_done <= 1'b1;
            conv_result <= 10'h2c7 + 10'(i);
            eight_bit_mode <= i[0];
            @(posedge mclk);
            conv_done <= 1'b0;
            #1 `CHK("channel", (i > w) ? 4'h0 : 4'(i), conv_channel)
        end
        wr(6'h01, 8'h00);
        #1 `CHK("abort", 6'h20, {seq_abort, seq_active, conv_channel})
    endtask : run_wrap
    task automatic results;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results
    // ****
    // Hang guard
    // ****
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            results();
        end
    end
    // ****
    // Main sequence
    // ****
    initial begin
        {reset_n, reg_wr, reg_rd, seq_start, conv_done, eight_bit_mode} = 6'h00;
        {reg_addr, reg_wdata, conv_result, analog_pin_level} = '0;
        dedicated_trigger_inputs = 4'h0;
        multi_channel_mode = 1'b1;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        rd(6'h00);
        `CHK("wrap reset", wrap_trig_pkg::WRAP_CTRL_RST, got)
        rd(6'h01);
        `CHK("trig reset", wrap_trig_pkg::TRIG_CTRL_RST, got)
        foreach (rows[k]) begin
            wr(rows[k][21:16], rows[k][15:8]);
            rd(rows[k][21:16]);
            `CHK("reg", rows[k][7:0], got)
        end
        @(posedge mclk);
        analog_pin_level <= 16'h3cf0;
        repeat (4) @(posedge mclk);
        rd(6'h0e);
        `CHK("pins high", 8'h24, got)
        rd(6'h0f);
        `CHK("pins low", 8'h50, got)
        for (int k = 0; k < 16; k++) begin
            trig({4'h0, 4'(k)}, 16'h1 << k, 4'h0, 1'b1);
            trig({4'h0, 4'(k)}, ~(16'h1 << k), 4'hf, 1'b0);
            trig({4'h8, 4'(k)}, 16'h0, (k < 4) ? 4'h1 << k : 4'hf, k < 4);
            trig({4'h8, 4'(k)}, 16'hffff, (k < 4) ? ~(4'h1 << k) : 4'h0, 1'b0);
        end
        run_wrap(1);
        run_wrap(15);
        for (int j = 0; j < 4; j++) begin
            rd(6'h10 + 6'(j));
            `CHK("result", res_exp[j], got)
        end
        // Start and control write together: the write must win
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= 6'h00;
        seq_start <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        seq_start <= 1'b0;
        #1 `CHK("no start", 1'b0, seq_active)
        results();
    end
endmodule : tb_top
